/* File: core/motion_profile_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - keeps sixteen profiles of up to sixteen steps in a retained array
// - four selector pins pick which of the sixteen profiles runs
// - execution pin starts the selected profile from its first step
// - steps run one at a time, in order, after completion
// - each step applies control until trigger is met, then acts
// - action code either advances to next step or stops
// - control types current, torque, velocity, position go to their loop
// - velocity command ramps with accel and decel limits in velocity and position steps
// - profile contents are only written while idle or stopped and drive disabled
// - stop codes disable, zero current, zero velocity, hold position
// - time trigger holds the step for its duration then acts
// - position steps take encoder targets, control value caps velocity
// - a new selection only takes effect once the profile ends
module motion_profile_sequencer
  import profile_seq_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  // selector and execution pins
  input  wire logic [SEL_W-1:0]       sel_pins,
  input  wire logic                   exec_pin,
  input  wire logic                   abort_pin,
  // profile loader, same clock domain
  input  wire logic                   load_we,
  input  wire logic [ADDR_W-1:0]      load_addr,
  input  wire logic [STEP_WORD_W-1:0] load_data,
  // trajectory limits and feedback, same clock domain
  input  wire logic [VAL_W-1:0]       accel_limit,
  input  wire logic [VAL_W-1:0]       decel_limit,
  input  wire logic signed [TRIG_W-1:0] pos_count,
  input  wire logic [TRIG_W-1:0]      torque_fb,
  input  wire logic [TRIG_W-1:0]      analog_fb,
  // loop commands
  output logic                        drive_en,
  output logic [1:0]                  loop_sel,
  output logic [VAL_W-1:0]            cur_cmd,
  output logic [VAL_W-1:0]            torq_cmd,
  output logic [VAL_W-1:0]            vel_cmd,
  output logic signed [TRIG_W-1:0]    pos_cmd,
  // status
  output logic                        running,
  output logic                        load_refused,
  output logic [SEL_W-1:0]            active_profile,
  output logic [STEP_W-1:0]           active_step
);
  initial
  begin
    if (TICK_CYC < 1)
      $error("motion_profile_sequencer: tick count below one");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SEL_W+1:0] pin_s1_reg;
  logic [SEL_W+1:0] pin_s2_reg;
  logic             exec_d_reg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      exec_d_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {abort_pin, exec_pin, sel_pins};
      pin_s2_reg <= pin_s1_reg;
      exec_d_reg <= pin_s2_reg[SEL_W];
    end
  end

  wire [SEL_W-1:0] sel_sync   = pin_s2_reg[SEL_W-1:0];
  wire             exec_rise  = pin_s2_reg[SEL_W] & ~exec_d_reg;
  wire             abort_sync = pin_s2_reg[SEL_W+1];

  // ------------------------------------------------------------
  // profile storage, retention is the memory macro's concern
  // ------------------------------------------------------------
  logic [STEP_WORD_W-1:0] prof_mem [NUM_PROFILES*NUM_STEPS];
  seq_state_t             state_reg;
  logic                   drive_en_reg;
  // a stopped profile with the drive disabled may be replaced, not only after reset
  wire                    seq_busy = state_reg == ST_FETCH || state_reg == ST_RUN;
  wire                    load_ok  = load_we && !seq_busy && !drive_en_reg;

  always_ff @(posedge ref_clk)
  begin
    if (load_ok)
      prof_mem[load_addr] <= load_data;
  end

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  logic [SEL_W-1:0]        prof_reg;
  logic [STEP_W-1:0]       step_reg;
  logic [STEP_WORD_W-1:0]  word_reg;
  logic [31:0]             tick_cnt_reg;
  logic [TRIG_W-1:0]       ticks_reg;
  logic signed [TRIG_W-1:0] pos_goal_reg;
  logic signed [TRIG_W-1:0] hold_pos_reg;
  action_t                 stop_act_reg;
  logic                    refused_reg;

  wire ctrl_type_t ctype = ctrl_type_t'(word_reg[CTYPE_LSB +: 2]);
  wire trig_type_t ttype = trig_type_t'(word_reg[TTYPE_LSB +: 3]);
  wire action_t    act   = action_t'(word_reg[ACT_LSB +: 3]);
  wire [VAL_W-1:0]  cval = word_reg[CVAL_LSB +: VAL_W];
  wire [TRIG_W-1:0] tval = word_reg[TVAL_LSB +: TRIG_W];
  wire              is_pos_trig = ttype == TR_POS_ABS || ttype == TR_POS_INC;

  // position steps accept only position triggers
  wire bad_step = (ctype == CT_POSITION) && !is_pos_trig;

  wire trig_met =
    (ttype == TR_TIME)   ? (ticks_reg >= tval) :
    (ttype == TR_TORQUE) ? (torque_fb >= tval) :
    (ttype == TR_ANALOG) ? (analog_fb >= tval) :
    is_pos_trig          ? (pos_count == pos_goal_reg) :
                           1'b1;

  wire             last_step  = step_reg == STEP_W'(NUM_STEPS - 1);
  // last step always stops, even when coded to advance
  wire             do_advance = act == ACT_NEXT && !last_step && !bad_step;
  wire             tick_hit   = tick_cnt_reg == 32'(TICK_CYC - 1);
  wire [ADDR_W-1:0] fetch_addr = {prof_reg, step_reg};
  wire signed [TRIG_W-1:0] goal =
    (ttype == TR_POS_INC) ? pos_count + $signed(tval) : $signed(tval);

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= ST_IDLE;
      prof_reg     <= '0;
      step_reg     <= '0;
      word_reg     <= '0;
      tick_cnt_reg <= '0;
      ticks_reg    <= '0;
      pos_goal_reg <= '0;
      hold_pos_reg <= '0;
      stop_act_reg <= ACT_ZERO_CUR;
      drive_en_reg <= 1'b0;
      refused_reg  <= 1'b0;
    end
    else
    begin
      refused_reg <= load_we && !load_ok;
      unique case (state_reg)
        ST_IDLE, ST_STOP:
        begin
          if (exec_rise)
          begin
            prof_reg     <= sel_sync;
            step_reg     <= '0;
            drive_en_reg <= 1'b1; // restart re-enables
            state_reg    <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          word_reg     <= prof_mem[fetch_addr];
          tick_cnt_reg <= '0;
          ticks_reg    <= '0;
          state_reg    <= ST_RUN;
        end
        ST_RUN:
        begin
          // exec edges are not looked at here
          tick_cnt_reg <= tick_hit ? '0 : tick_cnt_reg + 32'd1;
          if (tick_hit)
            ticks_reg <= ticks_reg + TRIG_W'(1);
          if (ticks_reg == '0 && tick_cnt_reg == '0 && is_pos_trig)
            pos_goal_reg <= goal;
          if (abort_sync || bad_step)
          begin
            stop_act_reg <= ACT_ZERO_CUR;
            state_reg    <= ST_STOP;
          end
          else if (trig_met && !(is_pos_trig && ticks_reg == '0 && tick_cnt_reg == '0))
          begin
            if (do_advance)
            begin
              step_reg  <= step_reg + STEP_W'(1);
              state_reg <= ST_FETCH;
            end
            else
            begin
              stop_act_reg <= (act == ACT_NEXT) ? ACT_ZERO_CUR : act;
              hold_pos_reg <= pos_count;
              if (act == ACT_DISABLE)
                drive_en_reg <= 1'b0;
              state_reg <= ST_STOP;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // loop command routing
  // ------------------------------------------------------------
  wire run_st   = state_reg == ST_RUN;
  wire ramp_on  = run_st && (ctype == CT_VELOCITY || ctype == CT_POSITION);
  wire [VAL_W-1:0] ramp_out;
  logic [1:0]              loop_sel_reg;
  logic [VAL_W-1:0]        cur_reg;
  logic [VAL_W-1:0]        torq_reg;
  logic [VAL_W-1:0]        vel_reg;
  logic signed [TRIG_W-1:0] pos_reg;

  // control value is the speed ceiling for moves
  velocity_ramp #(.W(VAL_W)) u_ramp
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .enable  (ramp_on),
    .target  (cval),
    .accel   (accel_limit),
    .decel   (decel_limit),
    .value   (ramp_out)
  );

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      loop_sel_reg <= CT_CURRENT;
      cur_reg      <= '0;
      torq_reg     <= '0;
      vel_reg      <= '0;
      pos_reg      <= '0;
    end
    else if (run_st)
    begin
      loop_sel_reg <= ctype;
      cur_reg      <= (ctype == CT_CURRENT) ? cval : '0;
      torq_reg     <= (ctype == CT_TORQUE) ? cval : '0;
      vel_reg      <= ramp_on ? ramp_out : '0;
      pos_reg      <= (ctype == CT_POSITION) ? pos_goal_reg : pos_count;
    end
    else if (state_reg == ST_STOP)
    begin
      loop_sel_reg <= (stop_act_reg == ACT_ZERO_VEL) ? CT_VELOCITY :
                      (stop_act_reg == ACT_HOLD_POS) ? CT_POSITION : CT_CURRENT;
      cur_reg      <= '0;
      torq_reg     <= '0;
      vel_reg      <= '0;
      pos_reg      <= hold_pos_reg;
    end
  end

  assign drive_en       = drive_en_reg;
  assign loop_sel       = loop_sel_reg;
  assign cur_cmd        = cur_reg;
  assign torq_cmd       = torq_reg;
  assign vel_cmd        = vel_reg;
  assign pos_cmd        = pos_reg;
  assign running        = state_reg == ST_FETCH || run_st;
  assign load_refused   = refused_reg;
  assign active_profile = prof_reg;
  assign active_step    = step_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_load_blocked;
    @(posedge ref_clk) disable iff (!nrst)
    (load_we && running) |=> load_refused;
  endproperty
  a_load_blocked: assert property (p_load_blocked) else $error("load accepted while running");

  property p_start_from_step0;
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == ST_IDLE && exec_rise) |=> (state_reg == ST_FETCH && step_reg == '0 && drive_en);
  endproperty
  a_start_from_step0: assert property (p_start_from_step0) else $error("start did not begin at step 0");

  property p_sel_latched;
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg != ST_RUN && state_reg != ST_FETCH && exec_rise) |=> active_profile == $past(sel_sync);
  endproperty
  a_sel_latched: assert property (p_sel_latched) else $error("profile not taken from selector");

  property p_profile_stable;
    @(posedge ref_clk) disable iff (!nrst)
    (run_st && $past(run_st)) |-> $stable(active_profile);
  endproperty
  a_profile_stable: assert property (p_profile_stable) else $error("profile changed mid run");

  property p_step_seq;
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == ST_FETCH && $past(run_st)) |-> active_step == $past(active_step) + STEP_W'(1);
  endproperty
  a_step_seq: assert property (p_step_seq) else $error("step skipped");

  property p_disable_stop;
    @(posedge ref_clk) disable iff (!nrst)
    (run_st && trig_met && act == ACT_DISABLE && !abort_sync && !bad_step &&
     !(is_pos_trig && ticks_reg == '0 && tick_cnt_reg == '0)) |=> !drive_en;
  endproperty
  a_disable_stop: assert property (p_disable_stop) else $error("disable stop left drive on");

  property p_time_not_early;
    @(posedge ref_clk) disable iff (!nrst)
    (run_st && ttype == TR_TIME && ticks_reg < tval) |=> state_reg == ST_RUN || $past(abort_sync) || $past(bad_step);
  endproperty
  a_time_not_early: assert property (p_time_not_early) else $error("time step ended early");

  property p_ignore_exec;
    @(posedge ref_clk) disable iff (!nrst)
    (run_st && exec_rise) |=> $stable(active_profile);
  endproperty
  a_ignore_exec: assert property (p_ignore_exec) else $error("exec accepted while running");
endmodule

`default_nettype wire

/* File: core/profile_seq_pkg.sv */
package profile_seq_pkg;

  // ------------------------------------------------------------
  // storage geometry
  // ------------------------------------------------------------
  localparam int NUM_PROFILES  = 16;
  localparam int NUM_STEPS     = 16;
  localparam int SEL_W         = 4;
  localparam int STEP_W        = 4;
  localparam int VAL_W         = 24;
  localparam int TRIG_W        = 32;
  localparam int ADDR_W        = SEL_W + STEP_W;

  // ------------------------------------------------------------
  // step word layout
  // ------------------------------------------------------------
  localparam int CTYPE_LSB     = 0;
  localparam int TTYPE_LSB     = 2;
  localparam int ACT_LSB       = 5;
  localparam int CVAL_LSB      = 8;
  localparam int TVAL_LSB      = CVAL_LSB + VAL_W;
  localparam int STEP_WORD_W   = TVAL_LSB + TRIG_W;

  // ------------------------------------------------------------
  // timing: one trigger time unit is one millisecond
  // ------------------------------------------------------------
  localparam int CLK_HZ        = 125_000_000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CT_CURRENT  = 2'h0,
    CT_TORQUE   = 2'h1,
    CT_VELOCITY = 2'h2,
    CT_POSITION = 2'h3
  } ctrl_type_t;

  typedef enum logic [2:0]
  {
    TR_TIME     = 3'h0,
    TR_TORQUE   = 3'h1,
    TR_ANALOG   = 3'h2,
    TR_POS_ABS  = 3'h3,
    TR_POS_INC  = 3'h4
  } trig_type_t;

  typedef enum logic [2:0]
  {
    ACT_NEXT      = 3'h0,
    ACT_DISABLE   = 3'h1,
    ACT_ZERO_CUR  = 3'h2,
    ACT_ZERO_VEL  = 3'h3,
    ACT_HOLD_POS  = 3'h4
  } action_t;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'h0,
    ST_FETCH  = 2'h1,
    ST_RUN    = 2'h2,
    ST_STOP   = 2'h3
  } seq_state_t;

endpackage

/* File: core/velocity_ramp.sv */
`timescale 1ns/1ps
`default_nettype none

module velocity_ramp
  import profile_seq_pkg::*;
#(
  parameter int W = VAL_W
)
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // control
  input  wire logic         enable,
  input  wire logic [W-1:0] target,
  input  wire logic [W-1:0] accel,
  input  wire logic [W-1:0] decel,
  // ramped value
  output logic      [W-1:0] value
);
  initial
  begin
    if (W < 2)
      $error("velocity_ramp: width too small");
  end

  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;
  wire          going_up   = target > value_reg;
  wire  [W-1:0] gap_up     = target - value_reg;
  wire  [W-1:0] gap_down   = value_reg - target;
  wire  [W-1:0] step_up    = (gap_up < accel) ? gap_up : accel;
  wire  [W-1:0] step_down  = (gap_down < decel) ? gap_down : decel;

  // without enable the ramp collapses to zero so a restart never jumps
  assign value_next = !enable  ? '0 :
                      going_up ? value_reg + step_up :
                                 value_reg - step_down;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      value_reg <= '0;
    else
      value_reg <= value_next;
  end

  assign value = value_reg;
endmodule

`default_nettype wire

/* File: tb/selector_host.sv */
`timescale 1ns/1ps
`default_nettype none

module selector_host
  import profile_seq_pkg::*;
(
  // clock
  input  wire logic             ref_clk,
  // pins toward the drive
  output var logic [SEL_W-1:0]  sel_pins,
  output var logic              exec_pin,
  output var logic              abort_pin
);
  initial
  begin
    sel_pins  = '0;
    exec_pin  = 1'b0;
    abort_pin = 1'b0;
  end

  // ------------------------------------------------------------
  // pin sequences
  // ------------------------------------------------------------
  // the number settles two cycles ahead of the start edge, so the synchroniser never sees it move
  task automatic start(input logic [SEL_W-1:0] sel);
    @(posedge ref_clk);
    #1 sel_pins = sel;
    repeat (2) @(posedge ref_clk);
    #1 exec_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 exec_pin = 1'b0;
  endtask

  task automatic abort_run();
    @(posedge ref_clk);
    #1 abort_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 abort_pin = 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: tb/motion_profile_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin $display("BAD %s exp %0h got %0h", nm, e, g); miscompares++; end end

module motion_profile_sequencer_tb;
  import profile_seq_pkg::*;

  localparam int TICKS     = 4;
  localparam int CYC_LIMIT = 20000;

  typedef struct packed
  {
    logic [SEL_W-1:0] sel;
    ctrl_type_t       ct;
    logic [VAL_W-1:0] cv;
    action_t          act;
  } row_t;

  logic                     ref_clk = 1'b0;
  logic                     nrst;
  wire  [SEL_W-1:0]         sel_pins;
  wire                      exec_pin;
  wire                      abort_pin;
  logic                     load_we;
  logic [ADDR_W-1:0]        load_addr;
  logic [STEP_WORD_W-1:0]   load_data;
  logic signed [TRIG_W-1:0] pos_count;
  logic [TRIG_W-1:0]        torque_fb;
  logic [TRIG_W-1:0]        analog_fb;
  logic                     drive_en;
  logic [1:0]               loop_sel;
  logic [VAL_W-1:0]         cur_cmd;
  logic [VAL_W-1:0]         torq_cmd;
  logic [VAL_W-1:0]         vel_cmd;
  logic signed [TRIG_W-1:0] pos_cmd;
  logic                     running;
  logic                     load_refused;
  logic [SEL_W-1:0]         active_profile;
  logic [STEP_W-1:0]        active_step;
  int                       miscompares = 0;
  int                       cmp_count   = 0;
  int                       cyc         = 0;
  row_t                     rows [3] = '{'{4'h1, CT_CURRENT, 24'h000123, ACT_ZERO_CUR},
                                         '{4'h2, CT_TORQUE, 24'h000456, ACT_ZERO_VEL},
                                         '{4'h3, CT_VELOCITY, 24'h000040, ACT_HOLD_POS}};

  always #4 ref_clk = ~ref_clk;

  selector_host selector_host_i (.ref_clk(ref_clk), .sel_pins(sel_pins), .exec_pin(exec_pin),
                                 .abort_pin(abort_pin));

  motion_profile_sequencer #(.TICK_CYC(TICKS)) motion_profile_sequencer_i (
    .ref_clk(ref_clk), .nrst(nrst), .sel_pins(sel_pins), .exec_pin(exec_pin), .abort_pin(abort_pin),
    .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
    .accel_limit(24'h000001), .decel_limit(24'h000001), .pos_count(pos_count),
    .torque_fb(torque_fb), .analog_fb(analog_fb),
    .drive_en(drive_en), .loop_sel(loop_sel), .cur_cmd(cur_cmd), .torq_cmd(torq_cmd),
    .vel_cmd(vel_cmd), .pos_cmd(pos_cmd), .running(running), .load_refused(load_refused),
    .active_profile(active_profile), .active_step(active_step));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [STEP_WORD_W-1:0] mk(ctrl_type_t ct, trig_type_t tt, action_t a,
                                                logic [VAL_W-1:0] cv, logic [TRIG_W-1:0] tv);
    return {tv, cv, a, tt, ct};
  endfunction

  task automatic load_word(input logic [ADDR_W-1:0] a, input logic [STEP_WORD_W-1:0] d);
    @(posedge ref_clk);
    #1 load_we = 1'b1;
    load_addr = a;
    load_data = d;
    @(posedge ref_clk);
    #1 load_we = 1'b0;
  endtask

  // bounded waits: a hang shows up as a miscompare instead of a stuck run
  task automatic wait_running(input logic v);
    int n;
    n = 0;
    while (running !== v && n < 40)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK("running", v, running)
  endtask

  task automatic wait_step(input logic [STEP_W-1:0] s);
    int n;
    n = 0;
    while (active_step !== s && n < 40)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK("active_step", s, active_step)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == CYC_LIMIT)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    nrst      = 1'b0;
    load_we   = 1'b0;
    load_addr = '0;
    load_data = '0;
    pos_count = 32'sh00000100;
    torque_fb = 32'h00000000;
    analog_fb = 32'h00000000;
    repeat (16) @(posedge ref_clk);
    #1 nrst = 1'b1;
    `CHK("drive_en", 1'b0, drive_en)
    `CHK("running", 1'b0, running)
    `CHK("loop_sel", 2'h0, loop_sel)
    foreach (rows[r])
    begin
      load_word({rows[r].sel, 4'h0}, mk(rows[r].ct, TR_TIME, ACT_NEXT, rows[r].cv, 32'h00000002));
      load_word({rows[r].sel, 4'h1}, mk(CT_CURRENT, TR_TIME, rows[r].act, 24'h0000AA, 32'h00000001));
    end
    load_word(8'h60, mk(CT_POSITION, TR_POS_ABS, ACT_DISABLE, 24'h000030, 32'h00000200));
    `CHK("load_refused", 1'b0, load_refused)
    // ordinary cases: two timed steps, then the stored stop
    foreach (rows[r])
    begin
      selector_host_i.start(rows[r].sel);
      wait_running(1'b1);
      settle(4);
      `CHK("active_profile", rows[r].sel, active_profile)
      `CHK("active_step", 4'h0, active_step)
      `CHK("loop_sel", rows[r].ct, loop_sel)
      if (rows[r].ct == CT_CURRENT)
        `CHK("cur_cmd", rows[r].cv, cur_cmd)
      else if (rows[r].ct == CT_TORQUE)
        `CHK("torq_cmd", rows[r].cv, torq_cmd)
      else
        `CHK("vel_ramp", 1'b1, (vel_cmd != 24'h0) && (vel_cmd < rows[r].cv))
      wait_step(4'h1);
      settle(3);
      `CHK("loop_sel", CT_CURRENT, loop_sel)
      `CHK("cur_cmd", 24'h0000AA, cur_cmd)
      wait_running(1'b0);
      settle(2);
      case (rows[r].act)
        ACT_ZERO_CUR: `CHK("cur_cmd", 24'h0, cur_cmd)
        ACT_ZERO_VEL: `CHK("vel_cmd", 24'h0, vel_cmd)
        default:      `CHK("pos_cmd", pos_count, pos_cmd)
      endcase
    end
    // position move waits on the encoder; a second start and a load meanwhile are refused
    selector_host_i.start(4'h6);
    wait_running(1'b1);
    selector_host_i.start(4'hF);
    `CHK("active_profile", 4'h6, active_profile)
    `CHK("loop_sel", CT_POSITION, loop_sel)
    `CHK("running", 1'b1, running)
    load_word(8'h61, mk(CT_CURRENT, TR_TIME, ACT_ZERO_CUR, 24'h000001, 32'h00000001));
    `CHK("load_refused", 1'b1, load_refused)
    pos_count = 32'sh00000200;
    wait_running(1'b0);
    settle(2);
    `CHK("drive_en", 1'b0, drive_en)
    load_word(8'h61, mk(CT_CURRENT, TR_TIME, ACT_ZERO_CUR, 24'h000001, 32'h00000001));
    `CHK("load_refused", 1'b0, load_refused)
    load_word(8'h70, mk(CT_TORQUE, TR_TORQUE, ACT_ZERO_CUR, 24'h000077, 32'h00000050));
    `CHK("load_refused", 1'b0, load_refused)
    // torque step holds until the torque feedback reaches its trigger value
    selector_host_i.start(4'h7);
    wait_running(1'b1);
    settle(4);
    `CHK("torq_cmd", 24'h000077, torq_cmd)
    `CHK("running", 1'b1, running)
    torque_fb = 32'h00000050;
    wait_running(1'b0);
    settle(2);
    `CHK("cur_cmd", 24'h0, cur_cmd)
    torque_fb = 32'h00000000;
    // restart after a zero-current stop, then abort mid-step
    selector_host_i.start(4'h1);
    wait_running(1'b1);
    `CHK("drive_en", 1'b1, drive_en)
    selector_host_i.abort_run();
    wait_running(1'b0);
    settle(2);
    `CHK("cur_cmd", 24'h0, cur_cmd)
    print_verdict();
  end
endmodule

`default_nettype wire
